/* bench/chop_model.sv */
// Behavioural current controller that chops both bridges
`timescale 1ns/10ps
module chop_model
(
  input wire logic clk, // System clock
  input wire logic ctrl_rst_n, // Controller reset, active low
  output logic chop_a, // Chopping level, bridge A
  output logic chop_b // Chopping level, bridge B
);
  logic [2:0] cnt_r;

  // Two unlike patterns so every chop pair shows up within eight cycles
  always_ff @(posedge clk or negedge ctrl_rst_n)
  begin
    if (!ctrl_rst_n)
    begin
      cnt_r <= 3'h0;
      chop_a <= 1'b0;
      chop_b <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_r + 3'h1;
      chop_a <= cnt_r[2];
      chop_b <= cnt_r[0] ^ cnt_r[1];
    end
  end
endmodule // chop_model

/* bench/tb_microstep_sequencer.sv */
// Self-checking bench for the microstep sequencer
`timescale 1ns/10ps
module tb_microstep_sequencer;
  import stepper_pkg::*;
  localparam int TB_POR = 8;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  apb_req_type req = '0;
  apb_rsp_type rsp;
  logic chop_a;
  logic chop_b;
  logic [3:0] phase_out;
  logic en_a_out;
  logic en_b_out;
  logic [3:0] br_in;
  logic [1:0] br_en;
  logic ctrl_rst_n;
  logic drv_clk;
  logic drv_rst_n;
  logic vref_a;
  logic vref_b;
  logic [31:0] rd;
  logic er;
  bit kept = 1'b0;
  logic [7:0] idx = 8'h00;
  logic [7:0] torque = 8'hff;
  logic [7:0] da;
  logic [7:0] db;
  int rises = 0;
  int cyc = 0;
  int na;
  int nb;
  int bad_count = 0;
  int num_checks = 0;
  logic [7:0] up_t [0:15] = '{8'hb4, 8'hc5, 8'hd4, 8'he0, 8'heb, 8'hf4, 8'hfa, 8'hfd,
    8'hfe, 8'hfd, 8'hfa, 8'hf4, 8'heb, 8'he0, 8'hd4, 8'hc5};
  logic [7:0] dn_t [0:15] = '{8'hb4, 8'ha1, 8'h8d, 8'h78, 8'h61, 8'h4a, 8'h31, 8'h18,
    8'h00, 8'h18, 8'h31, 8'h4a, 8'h61, 8'h78, 8'h8d, 8'ha1};
  logic [7:0] ctl_t [0:3] = '{8'ha6, 8'h53, 8'hf5, 8'h37};

  microstep_sequencer #(.POR_CYCLES(TB_POR)) dut (.clk(clk), .nrst(nrst), .apb_req(req),
    .apb_rsp(rsp), .chop_a(chop_a), .chop_b(chop_b), .phase_out(phase_out),
    .bridge_a_enable_out(en_a_out), .bridge_b_enable_out(en_b_out),
    .bridge_in_drive(br_in), .bridge_en_drive(br_en), .ctrl_rst_n(ctrl_rst_n),
    .drv_clk(drv_clk), .drv_rst_n(drv_rst_n), .vref_a_pwm(vref_a), .vref_b_pwm(vref_b));
  chop_model partner (.clk(clk), .ctrl_rst_n(ctrl_rst_n), .chop_a(chop_a), .chop_b(chop_b));

  always #10 clk = ~clk;

  always @(posedge drv_clk)
    rises++;

  // ****************
  // Tasks
  // ****************
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      bad_count++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Keep leaves the request up so the next call starts its setup at once
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input bit keep);
    // Only the bench timeout ends a wait for pready
    if (!kept)
      @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    kept = keep;
    if (!keep)
      req <= '0;
  endtask

  task automatic wait_idle();
    do
    begin
      xfer(1'b0, OFS_STATUS, 32'h0, 1'b0);
    end
    while (rd[STATUS_BUSY_BIT] !== 1'b0);
  endtask

  task automatic do_step(input logic rv);
    logic [7:0] p;
    logic [15:0] pa;
    logic [15:0] pb;
    logic ec;
    int r0;
    r0 = rises;
    xfer(1'b1, OFS_STEP, {30'h0, rv, 1'b1}, 1'b0);
    wait_idle();
    idx = rv ? idx - 8'h01 : idx + 8'h01;
    p = idx & 8'h1f;
    ec = rv ? (((p + 8'h01) & 8'h0e) == 8'h08) : ((p & 8'h0e) == 8'h08);
    chk("index", rd[7:0], idx);
    chk("direction", rd[STATUS_REV_BIT], rv);
    chk("drv_clk", drv_clk, ec);
    chk("clock rises", rises - r0, ec);
    chk("drv_rst_n", drv_rst_n, idx != 8'h00);
    pa = (p[4] ? dn_t[p[3:0]] : up_t[p[3:0]]) * torque;
    pb = (p[4] ? up_t[p[3:0]] : dn_t[p[3:0]]) * torque;
    da = pa[15:8];
    db = pb[15:8];
    xfer(1'b0, OFS_DUTY, 32'h0, 1'b0);
    chk("duty", rd[15:0], {db, da});
    chk("duty error", er, 1'b0);
  endtask

  task automatic decay(input logic [7:0] ctl);
    logic ca;
    logic cb;
    xfer(1'b1, OFS_CTRL, {24'h0, ctl}, 1'b0);
    repeat (3) @(negedge clk);
    chk("phase out", phase_out, ctl[7:4]);
    chk("bridge enables", {en_b_out, en_a_out}, ctl[2:1]);
    repeat (8)
    begin
      ca = chop_a;
      cb = chop_b;
      @(negedge clk);
      if (ctl[0])
      begin
        chk("fast in", br_in, ctl[7:4]);
        chk("fast en", br_en, {cb & ctl[2], ca & ctl[1]});
      end
      else
      begin
        chk("slow in", br_in, ctl[7:4] & {cb, cb, ca, ca});
        chk("slow en", br_en, ctl[2:1]);
      end
    end
  endtask

  // ****************
  // Tests
  // ****************
  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk("ctrl reset", ctrl_rst_n, 1'b0);
    chk("hold enables", br_en, 2'b00);
    xfer(1'b1, OFS_STEP, 32'h1, 1'b0);
    xfer(1'b0, OFS_STATUS, 32'h0, 1'b0);
    chk("early step", rd[7:0], 8'h00);
    repeat (TB_POR) @(posedge clk);
    xfer(1'b0, OFS_STATUS, 32'h0, 1'b0);
    chk("por done", rd[STATUS_POR_BIT], 1'b1);
    chk("ctrl released", ctrl_rst_n, 1'b1);
    xfer(1'b0, OFS_CTRL, 32'h0, 1'b0);
    chk("ctrl reset value", rd, 32'h0);
    chk("ctrl error", er, 1'b0);
    xfer(1'b0, OFS_TORQUE, 32'h0, 1'b0);
    chk("torque reset value", rd, 32'hff);
    xfer(1'b0, 12'h014, 32'h0, 1'b0);
    chk("unmapped data", rd, 32'h0);
    chk("unmapped error", er, 1'b1);
    $display("test reset done");
    xfer(1'b1, OFS_STEP, 32'h1, 1'b1);
    xfer(1'b1, OFS_STEP, 32'h1, 1'b0);
    wait_idle();
    idx = 8'h01;
    chk("busy refusal", rd[7:0], idx);
    $display("test busy done");
    torque = 8'h9d;
    xfer(1'b1, OFS_TORQUE, {24'h0, torque}, 1'b0);
    repeat (257) do_step(1'b0);
    $display("test forward done");
    torque = 8'h40;
    xfer(1'b1, OFS_TORQUE, {24'h0, torque}, 1'b0);
    repeat (40) do_step(1'b1);
    $display("test reverse done");
    na = 0;
    nb = 0;
    repeat (256)
    begin
      @(negedge clk);
      na += vref_a;
      nb += vref_b;
    end
    chk("pwm a", na, da);
    chk("pwm b", nb, db);
    $display("test pwm done");
    foreach (ctl_t[i]) decay(ctl_t[i]);
    $display("test decay done");
    close_out();
  end
endmodule // tb_microstep_sequencer

/* hw/duty_pwm.sv */
// Free-running PWM that turns a duty value into a filtered reference drive
`timescale 1ns/10ps
module duty_pwm
  import stepper_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic [7:0] duty, // High time in counts of 256
  output logic pwm_out // Registered PWM level
);

  pwm_state_type s_r;
  pwm_state_type s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.cnt = s_r.cnt + 8'h01;
    s_nxt.pwm = s_r.cnt < duty;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign pwm_out = s_r.pwm;

endmodule // duty_pwm

/* hw/microstep_sequencer.sv */
// Microstep sequencer for a two-phase stepper, APB slave, top level
//
// How it works
// - Each phase current reference comes from its own PWM duty output.
// - Four phase-direction outputs plus one enable output per bridge.
// - Slow decay: chopping gates the normally high phase input of each bridge.
// - Fast decay: chopping drives bridge enables, phase outputs drive polarity directly.
// - Fast decay: bridge enable outputs gate controller inputs for zero current.
// - Power-on reset holds the controller in reset, bridges disabled.
// - Each step first returns the driver clock output low.
// - Forward step increments the 8-bit index, reverse decrements it.
// - Driver reset high normally, asserted from the step where index reaches zero until the next step.
// - Lowest five index bits address the sine lookup, 32 positions.
// - Forward: driver clock rises when masked index bits 3..1 equal 8.
// - Reverse: index plus one is masked, so positions 7, 8, 23 and 24 clock the driver.
// - Lookup holds sine magnitudes, full scale 256, 16 entries per step.
// - Phase A looks up from 45 degrees, phase B from 135 degrees.
// - Duty equals table value times torque factor, upper byte kept.
// - Table values follow the given phase A and phase B sequences.
`timescale 1ns/10ps
module microstep_sequencer
  import stepper_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYCLES_DEF
)
(
  input wire logic clk, // System clock, 50 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire apb_req_type apb_req, // APB request signals
  output apb_rsp_type apb_rsp, // APB answer signals
  input wire logic chop_a, // Current chopping level, bridge A
  input wire logic chop_b, // Current chopping level, bridge B
  output logic [3:0] phase_out, // Phase-direction outputs
  output logic bridge_a_enable_out, // Bridge A enable
  output logic bridge_b_enable_out, // Bridge B enable
  output logic [3:0] bridge_in_drive, // Bridge polarity inputs after decay routing
  output logic [1:0] bridge_en_drive, // Bridge enable inputs after decay routing
  output logic ctrl_rst_n, // Current controller reset, active low
  output logic drv_clk, // Driver step clock
  output logic drv_rst_n, // Driver sequence reset, active low
  output logic vref_a_pwm, // Phase A reference PWM
  output logic vref_b_pwm // Phase B reference PWM
);

  // ********************************
  // Elaboration checks
  // ********************************
  if (POR_CYCLES < 1 || POR_CYCLES >= 2 ** POR_CNT_W)
  begin : g_bad_por
    $error("POR_CYCLES out of range for the counter");
  end

  localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_CYCLES - 1);

  seq_state_type s_r;
  seq_state_type s_nxt;
  logic access;
  logic wr;
  logic step_go;

  // ********************************
  // Next state
  // ********************************
  always_comb
  begin
    s_nxt = s_r;
    access = apb_req.psel && apb_req.penable && !s_r.rsp.pready;
    wr = access && apb_req.pwrite;
    step_go = wr && (apb_req.paddr == OFS_STEP) && apb_req.pwdata[STEP_GO_BIT]
      && (s_r.fsm == ST_IDLE) && s_r.por_done;

    // Power-on hold of the controller
    if (!s_r.por_done)
    begin
      if (s_r.por_cnt == POR_LAST)
      begin
        s_nxt.por_done = 1'b1;
      end
      s_nxt.por_cnt = s_r.por_cnt + POR_CNT_W'(1);
    end
    s_nxt.ctrl_rst_n = s_r.por_done;

    // APB slave: one wait state, then pready for one cycle
    s_nxt.rsp.pready = access;
    s_nxt.rsp.pslverr = 1'b0;
    if (access)
    begin
      s_nxt.rsp.prdata = '0;
      case (apb_req.paddr)
        OFS_CTRL:
        begin
          s_nxt.rsp.prdata[CTRL_FAST_BIT] = s_r.fast;
          s_nxt.rsp.prdata[CTRL_EN_A_BIT] = s_r.en_a;
          s_nxt.rsp.prdata[CTRL_EN_B_BIT] = s_r.en_b;
          s_nxt.rsp.prdata[CTRL_PHASE_LSB +: 4] = s_r.phase;
          if (apb_req.pwrite)
          begin
            s_nxt.fast = apb_req.pwdata[CTRL_FAST_BIT];
            s_nxt.en_a = apb_req.pwdata[CTRL_EN_A_BIT];
            s_nxt.en_b = apb_req.pwdata[CTRL_EN_B_BIT];
            s_nxt.phase = apb_req.pwdata[CTRL_PHASE_LSB +: 4];
          end
        end
        OFS_STEP:
        begin
          s_nxt.rsp.prdata = '0;
        end
        OFS_TORQUE:
        begin
          s_nxt.rsp.prdata[7:0] = s_r.torque;
          if (apb_req.pwrite)
          begin
            s_nxt.torque = apb_req.pwdata[7:0];
          end
        end
        OFS_STATUS:
        begin
          s_nxt.rsp.prdata[7:0] = s_r.idx;
          s_nxt.rsp.prdata[STATUS_REV_BIT] = s_r.rev;
          s_nxt.rsp.prdata[STATUS_BUSY_BIT] = s_r.fsm != ST_IDLE;
          s_nxt.rsp.prdata[STATUS_POR_BIT] = s_r.por_done;
        end
        OFS_DUTY:
        begin
          s_nxt.rsp.prdata[7:0] = s_r.duty_a;
          s_nxt.rsp.prdata[DUTY_B_LSB +: 8] = s_r.duty_b;
        end
        default:
        begin
          s_nxt.rsp.pslverr = 1'b1;
        end
      endcase
    end

    // Step engine, four cycles per request
    case (s_r.fsm)
      ST_IDLE:
      begin
        if (step_go)
        begin
          s_nxt.rev = apb_req.pwdata[STEP_REV_BIT];
          s_nxt.drv_clk = 1'b0;
          if (apb_req.pwdata[STEP_REV_BIT])
          begin
            s_nxt.idx = s_r.idx - 8'h01;
          end
          else
          begin
            s_nxt.idx = s_r.idx + 8'h01;
          end
          s_nxt.drv_rst_n = s_nxt.idx != 8'h00;
          s_nxt.fsm = ST_UPDATE;
        end
      end
      ST_UPDATE:
      begin
        s_nxt.drv_clk = clock_edge(s_r.idx, s_r.rev);
        s_nxt.tab_a = sine_at(PHASE_A_BASE, s_r.idx);
        s_nxt.tab_b = sine_at(PHASE_B_BASE, s_r.idx);
        s_nxt.fsm = ST_LOOKUP;
      end
      ST_LOOKUP:
      begin
        s_nxt.duty_a = scale_duty(s_r.tab_a, s_r.torque);
        s_nxt.duty_b = scale_duty(s_r.tab_b, s_r.torque);
        s_nxt.fsm = ST_SCALE;
      end
      ST_SCALE:
      begin
        s_nxt.fsm = ST_IDLE;
      end
      default:
      begin
        s_nxt.fsm = ST_IDLE;
      end
    endcase

    // Bridge routing; enables stay off until the controller leaves reset
    s_nxt.phase_out = s_r.phase;
    s_nxt.en_a_out = s_r.en_a && s_r.por_done;
    s_nxt.en_b_out = s_r.en_b && s_r.por_done;
    if (!s_r.por_done)
    begin
      s_nxt.bridge_in = '0;
      s_nxt.bridge_en = '0;
    end
    else if (s_r.fast)
    begin
      s_nxt.bridge_in = s_r.phase;
      s_nxt.bridge_en = {chop_b && s_r.en_b, chop_a && s_r.en_a};
    end
    else
    begin
      // Only the high phase input of a pair carries the chopping
      s_nxt.bridge_in = s_r.phase & {chop_b, chop_b, chop_a, chop_a};
      s_nxt.bridge_en = {s_r.en_b, s_r.en_a};
    end
  end

  // ********************************
  // State register
  // ********************************
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_r <= '0;
      s_r.fsm <= ST_IDLE;
      s_r.idx <= IDX_RST;
      s_r.phase <= PHASE_RST;
      s_r.torque <= TORQUE_RST;
      s_r.drv_rst_n <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ********************************
  // Reference PWM outputs
  // ********************************
  duty_pwm u_pwm_a (
    .clk(clk),
    .nrst(nrst),
    .duty(s_r.duty_a),
    .pwm_out(vref_a_pwm)
  );

  duty_pwm u_pwm_b (
    .clk(clk),
    .nrst(nrst),
    .duty(s_r.duty_b),
    .pwm_out(vref_b_pwm)
  );

  assign apb_rsp = s_r.rsp;
  assign phase_out = s_r.phase_out;
  assign bridge_a_enable_out = s_r.en_a_out;
  assign bridge_b_enable_out = s_r.en_b_out;
  assign bridge_in_drive = s_r.bridge_in;
  assign bridge_en_drive = s_r.bridge_en;
  assign ctrl_rst_n = s_r.ctrl_rst_n;
  assign drv_clk = s_r.drv_clk;
  assign drv_rst_n = s_r.drv_rst_n;

  // ********************************
  // Assertions
  // ********************************
  property p_step_index;
    @(posedge clk) disable iff (!nrst)
    step_go |=> (s_r.fsm == ST_UPDATE)
      && (s_r.idx == $past(s_r.idx) + ($past(apb_req.pwdata[STEP_REV_BIT]) ? 8'hff : 8'h01));
  endproperty
  a_step_index: assert property (p_step_index) else $error("step index not moved by one");

  property p_clk_low;
    @(posedge clk) disable iff (!nrst)
    step_go |=> !drv_clk;
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("driver clock not low at update");

  property p_clk_edge;
    @(posedge clk) disable iff (!nrst)
    (s_r.fsm == ST_UPDATE) |=> drv_clk == clock_edge($past(s_r.idx), $past(s_r.rev));
  endproperty
  a_clk_edge: assert property (p_clk_edge) else $error("driver clock edge wrong");

  property p_wrap_reset;
    @(posedge clk) disable iff (!nrst)
    $past(step_go) |-> drv_rst_n == (s_r.idx != 8'h00);
  endproperty
  a_wrap_reset: assert property (p_wrap_reset) else $error("driver reset not tied to wrap");

  property p_lookup;
    @(posedge clk) disable iff (!nrst)
    (s_r.fsm == ST_LOOKUP) |-> s_r.tab_a == SINE_TABLE[s_r.idx[4:0]]
      && s_r.tab_b == SINE_TABLE[6'(s_r.idx[4:0]) + PHASE_B_BASE];
  endproperty
  a_lookup: assert property (p_lookup) else $error("sine lookup mismatch");

  property p_duty;
    @(posedge clk) disable iff (!nrst)
    (s_r.fsm == ST_LOOKUP) ##1 (s_r.fsm == ST_SCALE)
      |-> s_r.duty_a == scale_duty($past(s_r.tab_a), $past(s_r.torque));
  endproperty
  a_duty: assert property (p_duty) else $error("phase A duty not scaled");

  property p_update_len;
    @(posedge clk) disable iff (!nrst)
    step_go |=> (s_r.fsm == ST_UPDATE) ##1 (s_r.fsm == ST_LOOKUP)
      ##1 (s_r.fsm == ST_SCALE) ##1 (s_r.fsm == ST_IDLE);
  endproperty
  a_update_len: assert property (p_update_len) else $error("step update sequence broken");

  property p_por_hold;
    @(posedge clk) disable iff (!nrst)
    !s_r.por_done |=> !ctrl_rst_n && (bridge_en_drive == 2'b00);
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("bridges live during power-up");

  property p_fast_route;
    @(posedge clk) disable iff (!nrst)
    (s_r.por_done && s_r.fast) |=> bridge_in_drive == $past(s_r.phase)
      && bridge_en_drive == $past({chop_b && s_r.en_b, chop_a && s_r.en_a});
  endproperty
  a_fast_route: assert property (p_fast_route) else $error("fast decay routing wrong");

  property p_slow_route;
    @(posedge clk) disable iff (!nrst)
    (s_r.por_done && !s_r.fast) |=> bridge_in_drive
      == $past(s_r.phase & {chop_b, chop_b, chop_a, chop_a});
  endproperty
  a_slow_route: assert property (p_slow_route) else $error("slow decay routing wrong");

  property p_duty_b;
    @(posedge clk) disable iff (!nrst)
    (s_r.fsm == ST_LOOKUP) ##1 (s_r.fsm == ST_SCALE)
      |-> s_r.duty_b == scale_duty($past(s_r.tab_b), $past(s_r.torque));
  endproperty
  a_duty_b: assert property (p_duty_b) else $error("phase B duty not scaled");

  property p_enable_out;
    @(posedge clk) disable iff (!nrst)
    s_r.por_done |=> bridge_a_enable_out == $past(s_r.en_a)
      && bridge_b_enable_out == $past(s_r.en_b);
  endproperty
  a_enable_out: assert property (p_enable_out) else $error("bridge enable output wrong");

  property p_phase_out;
    @(posedge clk) disable iff (!nrst)
    s_r.por_done |=> phase_out == $past(s_r.phase);
  endproperty
  a_phase_out: assert property (p_phase_out) else $error("phase output wrong");

  property p_rst_hold;
    @(posedge clk) disable iff (!nrst)
    !step_go |=> drv_rst_n == $past(drv_rst_n);
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("driver reset moved without step");

  property p_busy_hold;
    @(posedge clk) disable iff (!nrst)
    (s_r.fsm != ST_IDLE) |=> s_r.idx == $past(s_r.idx);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("index moved while busy");

endmodule // microstep_sequencer

/* hw/stepper_pkg.sv */
// Constants, types and helpers shared by the microstep sequencer
package stepper_pkg;

  // ********************************
  // Timing
  // ********************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int POR_TIME_NS = 100000;
  localparam int POR_CYCLES_DEF = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_CNT_W = 16;

  // ********************************
  // Register map
  // ********************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STEP = 12'h004;
  localparam logic [11:0] OFS_TORQUE = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [11:0] OFS_DUTY = 12'h010;

  localparam int CTRL_FAST_BIT = 0;
  localparam int CTRL_EN_A_BIT = 1;
  localparam int CTRL_EN_B_BIT = 2;
  localparam int CTRL_PHASE_LSB = 4;
  localparam int STEP_GO_BIT = 0;
  localparam int STEP_REV_BIT = 1;
  localparam int STATUS_REV_BIT = 8;
  localparam int STATUS_BUSY_BIT = 9;
  localparam int STATUS_POR_BIT = 10;
  localparam int DUTY_B_LSB = 8;

  localparam logic [3:0] PHASE_RST = 4'h0;
  localparam logic [7:0] TORQUE_RST = 8'hff;
  localparam logic [7:0] IDX_RST = 8'h00;

  // ********************************
  // Step index decoding
  // ********************************
  localparam logic [7:0] LOOKUP_MASK = 8'h1f;
  localparam logic [7:0] CLK_MASK = 8'h0e;
  localparam logic [7:0] CLK_MATCH = 8'h08;
  localparam logic [5:0] PHASE_A_BASE = 6'h00;
  localparam logic [5:0] PHASE_B_BASE = 6'h10;

  // Sine magnitude, full scale 256, 16 entries per full step
  localparam logic [7:0] SINE_TABLE [0:47] = '{
    8'hb4, 8'hc5, 8'hd4, 8'he0, 8'heb, 8'hf4, 8'hfa, 8'hfd,
    8'hfe, 8'hfd, 8'hfa, 8'hf4, 8'heb, 8'he0, 8'hd4, 8'hc5,
    8'hb4, 8'ha1, 8'h8d, 8'h78, 8'h61, 8'h4a, 8'h31, 8'h18,
    8'h00, 8'h18, 8'h31, 8'h4a, 8'h61, 8'h78, 8'h8d, 8'ha1,
    8'hb4, 8'hc5, 8'hd4, 8'he0, 8'heb, 8'hf4, 8'hfa, 8'hfd,
    8'hfe, 8'hfd, 8'hfa, 8'hf4, 8'heb, 8'he0, 8'hd4, 8'hc5
  };

  // ********************************
  // Types
  // ********************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_UPDATE = 2'b01,
    ST_LOOKUP = 2'b11,
    ST_SCALE = 2'b10
  } step_state_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;

  typedef struct packed {
    step_state_type fsm;
    logic [7:0] idx;
    logic rev;
    logic [7:0] tab_a;
    logic [7:0] tab_b;
    logic [7:0] duty_a;
    logic [7:0] duty_b;
    logic fast;
    logic en_a;
    logic en_b;
    logic [3:0] phase;
    logic [7:0] torque;
    logic [POR_CNT_W-1:0] por_cnt;
    logic por_done;
    logic ctrl_rst_n;
    logic drv_clk;
    logic drv_rst_n;
    logic [3:0] phase_out;
    logic en_a_out;
    logic en_b_out;
    logic [3:0] bridge_in;
    logic [1:0] bridge_en;
    apb_rsp_type rsp;
  } seq_state_type;

  typedef struct packed {
    logic [7:0] cnt;
    logic pwm;
  } pwm_state_type;

  // ********************************
  // Helpers
  // ********************************
  function automatic logic [7:0] scale_duty(input logic [7:0] value, input logic [7:0] torque);
    logic [15:0] prod;
    prod = value * torque;
    return prod[15:8];
  endfunction

  function automatic logic [7:0] sine_at(input logic [5:0] base, input logic [7:0] idx);
    logic [7:0] pos;
    pos = idx & LOOKUP_MASK;
    return SINE_TABLE[base + pos[5:0]];
  endfunction

  function automatic logic clock_edge(input logic [7:0] idx, input logic rev);
    logic [7:0] pos;
    pos = idx & LOOKUP_MASK;
    if (rev)
    begin
      pos = pos + 8'h01;
    end
    return (pos & CLK_MASK) == CLK_MATCH;
  endfunction

endpackage
